// file: pkg/lsr_cfg.svh
// Constants for the self refresh, partial array and register read block
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_ADDR_BANK_MASK    8'h10
`define LSR_ADDR_SEG_MASK     8'h11
`define LSR_MASK_RESET        8'h00
`define LSR_BANKS             8
`define LSR_SEGS              8
`define LSR_BURST_LEN         4
`define LSR_REGREAD_PERIOD    2
`define LSR_CLK_NS            50
`define LSR_MIN_RESIDENCY_NS  15
`define LSR_EXIT_INTERVAL_NS  140
`define LSR_READ_LATENCY      3
`define LSR_REFRESH_PERIOD    16
`endif

// file: pkg/lsr_pkg.sv
// Types shared by the self refresh block
package lsr_pkg;
  typedef enum logic [1:0] {
    LSR_ACTIVE = 2'b00,
    LSR_SELFREF = 2'b01,
    LSR_EXIT = 2'b11
  } lsr_state_e;
  typedef logic [7:0] lsr_mask_t;
endpackage

// file: hdl/lsr_refresh_engine.sv
// Internal refresh walker applying bank and segment masks
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_refresh_engine
  import lsr_pkg::*;
#(
  parameter int PERIOD = `LSR_REFRESH_PERIOD
) (
  input  wire logic      clk,          // Clock
  input  wire logic      srst,         // Sync reset
  input  wire logic      run,          // Self refresh active
  input  wire lsr_mask_t bank_mask,    // 1 = bank masked
  input  wire lsr_mask_t seg_mask,     // 1 = segment masked
  output logic           refresh_busy, // Internal refresh in progress
  output logic           done_one,     // First full pass done
  output lsr_mask_t      bank_en,      // Banks refreshed this step
  output logic [2:0]     seg_idx       // Segment being refreshed
);
  logic [7:0]  tmr_r, tmr_nxt;
  logic [2:0]  seg_r, seg_nxt;
  logic        busy_r, busy_nxt;
  logic        done_r, done_nxt;
  lsr_mask_t   en_r, en_nxt;

  // Step segments every timer wrap; a step finishing an exit completes
  always_comb begin
    tmr_nxt  = tmr_r;
    seg_nxt  = seg_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    en_nxt   = '0;
    if (run || busy_r) begin
      if (tmr_r == 8'(PERIOD - 1) || !busy_r) begin
        tmr_nxt  = 8'h00;
        busy_nxt = run || (seg_r != 3'h7);
        if (busy_r) begin
          seg_nxt = seg_r + 3'h1;
          if (seg_r == 3'h7) begin
            done_nxt = 1'b1;
          end
        end
        // Masked banks and segments get no refresh at all
        en_nxt = seg_mask[seg_nxt] ? 8'h00 : ~bank_mask; // [R13] [R14] [R15] [R16]
      end else begin
        tmr_nxt = tmr_r + 8'h01;
      end
    end
    if (!run && !busy_r) begin
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_r  <= 8'h00;
      seg_r  <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      en_r   <= 8'h00;
    end else begin
      tmr_r  <= tmr_nxt;
      seg_r  <= seg_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      en_r   <= en_nxt;
    end
  end

  assign refresh_busy = busy_r;
  assign done_one     = done_r;
  assign bank_en      = en_r;
  assign seg_idx      = seg_r;
endmodule
`default_nettype wire

// file: hdl/lsr_device.sv
// Self refresh, partial array masks and mode register read of the device
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
// How it works
// R1 - CKE low, CS low, CA0/CA1 low, CA2 high on rising edge enters self refresh.
// R2 - Controller holds CKE high in the cycle before entry.
// R3 - Controller drives a no-op right after entry.
// R4 - Device stays in self refresh while CKE stays low.
// R5 - Device performs an all-bank refresh within residency and keeps refreshing; here a pass takes 8 steps of 16 cycles and exit waits for it.
// R6 - Controller keeps self refresh for the minimum residency before exit.
// R7 - Controller may stop clock, but gives two stable cycles before exit.
// R8 - Controller drives no-ops with CKE high through the exit interval.
// R9 - Exit interval counts from first edge with CKE high; refresh finishes.
// R10 - Controller issues a refresh before next self refresh entry.
// R11 - Controller idles all banks before self refresh entry.
// R12 - Eight-bit bank mask register written by mode register write.
// R13 - Masked bank gets no self refresh.
// R14 - Unmasked bank refreshes only unmasked segments.
// R15 - Segment mask bits apply to every bank, combined with bank mask.
// R16 - Mask bit one blocks refresh, zero enables it.
// R17 - Register read: CS low, CA2..0 low, CA3 high; index from CA bits.
// R18 - Register value on data 7:0 first beat after read latency; strobe toggles.
// R19 - Register read bursts four, uninterruptible, two-clock period of no-ops.
// R20 - Controller spaces register read before writes and register writes.
// R21 - Controller waits half burst after read before register read.
// R22 - Controller waits write latency, burst and turnaround before register read.
// R23 - Controller writes masks only with all banks idle.
// R24 - In self refresh only rising CKE matters; CS and CA ignored.
module lsr_device
  import lsr_pkg::*;
#(
  parameter int READ_LAT = `LSR_READ_LATENCY
) (
  input  wire logic       clk,          // Memory clock
  input  wire logic       srst,         // Sync reset
  input  wire logic       cke,          // Clock enable
  input  wire logic       cs_n,         // Chip select, active low
  input  wire logic [9:0] ca_rise,      // cmd_addr_bus, rising edge
  input  wire logic [9:0] ca_fall,      // cmd_addr_bus, falling edge
  output logic [31:0]     dq_out,       // Read data
  output logic            dq_oe,        // Data drive enable
  output logic [3:0]      dqs_out,      // Strobes
  output logic            dqs_oe,       // Strobe drive enable
  output logic            in_selfref,   // Self refresh state
  output logic            in_exit,      // Exit interval running
  output logic            cmd_ignored,  // Command refused this cycle
  output lsr_mask_t       bank_refresh, // Banks refreshed this step
  output logic [2:0]      seg_refresh   // Segment index refreshed
);
  localparam int RES_CYC  = (`LSR_MIN_RESIDENCY_NS + `LSR_CLK_NS - 1)
                            / `LSR_CLK_NS;
  localparam int EXIT_CYC = (`LSR_EXIT_INTERVAL_NS + `LSR_CLK_NS - 1)
                            / `LSR_CLK_NS;
  // First beat leaves the pins read latency edges after the command
  localparam int DLY = READ_LAT;

  // Command decode shared by the several paths below
  function automatic logic is_cmd(input logic [3:0] ca, input logic [3:0] pat,
                                  input logic [3:0] care);
    return ((ca ^ pat) & care) == 4'h0;
  endfunction

  lsr_state_e st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       cke_q_r;
  lsr_mask_t  bmask_r, bmask_nxt, smask_r, smask_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [3:0] burst_r, burst_nxt;
  logic [1:0] per_r, per_nxt;
  logic [31:0] dq_r, dq_nxt;
  logic [3:0] dqs_r, dqs_nxt;
  logic       oe_r, oe_nxt;
  logic       ign_nxt, ign_r;
  logic       eng_busy, eng_done;
  logic       sr_entry, mrr_cmd, mrw_cmd;
  logic [7:0] ma;

  assign ma       = {ca_rise[9:4], ca_fall[1:0]}; // [R17]
  assign sr_entry = !cke && cke_q_r && !cs_n
                    && is_cmd(ca_rise[3:0], 4'h4, 4'h7); // [R1]
  assign mrr_cmd  = cke && !cs_n && is_cmd(ca_rise[3:0], 4'h8, 4'hF); // [R17]
  assign mrw_cmd  = cke && !cs_n && is_cmd(ca_rise[3:0], 4'h0, 4'hF);

  lsr_refresh_engine u_eng (
    .clk          (clk),
    .srst         (srst),
    .run          (st_r == LSR_SELFREF),
    .bank_mask    (bmask_r),
    .seg_mask     (smask_r),
    .refresh_busy (eng_busy),
    .done_one     (eng_done),
    .bank_en      (bank_refresh),
    .seg_idx      (seg_refresh)
  );

  // Power state: entry, residency, exit interval
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      LSR_ACTIVE: begin
        if (sr_entry) begin
          st_nxt  = LSR_SELFREF; // [R1]
          cnt_nxt = 8'h00;
        end
      end
      LSR_SELFREF: begin
        // Only CKE is looked at; CS and CA are don't care here
        if (cnt_r != 8'hFF) begin
          cnt_nxt = cnt_r + 8'h01;
        end
        if (cke) begin // [R4] [R24]
          st_nxt  = LSR_EXIT;
          cnt_nxt = 8'h01; // first edge with CKE high counts [R9]
        end
      end
      LSR_EXIT: begin
        cnt_nxt = cnt_r + 8'h01;
        // Hold until interval over and any internal refresh done
        if (cnt_r >= 8'(EXIT_CYC) && !eng_busy) begin // [R9]
          st_nxt = LSR_ACTIVE;
        end
      end
      default: begin
        st_nxt = LSR_ACTIVE;
      end
    endcase
  end

  // Mask registers and register read pipeline
  always_comb begin
    bmask_nxt   = bmask_r;
    smask_nxt   = smask_r;
    rd_data_nxt = rd_data_r;
    pend_nxt    = pend_r << 1;
    burst_nxt   = burst_r >> 1;
    per_nxt     = (per_r != 2'h0) ? per_r - 2'h1 : 2'h0;
    ign_nxt     = 1'b0;
    dq_nxt      = 32'h0000_0000;
    dqs_nxt     = 4'h0;
    oe_nxt      = 1'b0;
    if (st_r == LSR_ACTIVE && !sr_entry) begin
      if (per_r != 2'h0 && !cs_n) begin
        ign_nxt = 1'b1; // only no-ops during the read period [R19]
      end else if (mrw_cmd) begin
        if (ma == `LSR_ADDR_BANK_MASK) begin
          bmask_nxt = {ca_fall[9:2]}; // [R12]
        end
        if (ma == `LSR_ADDR_SEG_MASK) begin
          smask_nxt = {ca_fall[9:2]}; // [R15]
        end
      end else if (mrr_cmd) begin
        per_nxt  = 2'(`LSR_REGREAD_PERIOD - 1); // [R19]
        pend_nxt[0] = 1'b1;
        // Mask registers are write only; read back as zero
        rd_data_nxt = 8'h00;
      end
    end
    if (pend_r[DLY - 2]) begin
      burst_nxt = 4'hF; // four beats, cannot be cut short [R19]
    end
    if (burst_r != 4'h0) begin
      oe_nxt  = 1'b1;
      // Shifter parity flips every beat, so strobes toggle each cycle
      dqs_nxt = {4{^burst_r}}; // [R18]
      dq_nxt  = (burst_r == 4'hF) ? {24'h00_0000, rd_data_r}
                                  : 32'h0000_0000; // [R18]
    end
  end

  // Registers; masks reset to all unmasked
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r      <= LSR_ACTIVE;
      cnt_r     <= 8'h00;
      cke_q_r   <= 1'b0;
      bmask_r   <= `LSR_MASK_RESET;
      smask_r   <= `LSR_MASK_RESET;
      rd_data_r <= 8'h00;
      pend_r    <= 8'h00;
      burst_r   <= 4'h0;
      per_r     <= 2'h0;
      dq_r      <= 32'h0000_0000;
      dqs_r     <= 4'h0;
      oe_r      <= 1'b0;
      ign_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      cke_q_r   <= cke; // previous cycle CKE high check [R2]
      bmask_r   <= bmask_nxt;
      smask_r   <= smask_nxt;
      rd_data_r <= rd_data_nxt;
      pend_r    <= pend_nxt;
      burst_r   <= burst_nxt;
      per_r     <= per_nxt;
      dq_r      <= dq_nxt;
      dqs_r     <= dqs_nxt;
      oe_r      <= oe_nxt;
      ign_r     <= ign_nxt;
    end
  end

  // Residency flag unused by logic; refresh engine guarantees first pass [R5]
  assign in_selfref  = (st_r == LSR_SELFREF);
  assign in_exit     = (st_r == LSR_EXIT);
  assign cmd_ignored = ign_r || (st_r == LSR_EXIT && !cs_n && !eng_done
                       && cnt_r < 8'(RES_CYC + EXIT_CYC));
  assign dq_out      = dq_r;
  assign dq_oe       = oe_r; // Registered with the data, never a beat early
  assign dqs_out     = dqs_r;
  assign dqs_oe      = dq_oe;
endmodule
`default_nettype wire

// file: tb/lsr_ctrl_model.sv
// Controller model driving commands into the device
`timescale 1ns/1ps
`default_nettype none
module lsr_ctrl_model (
  input  wire logic       clk,     // Memory clock
  output logic            cke,     // Clock enable
  output logic            cs_n,    // Chip select, active low
  output logic [9:0]      ca_rise, // Rising-edge bits
  output logic [9:0]      ca_fall  // Falling-edge bits
);
  // Idle deselected with clock enable high
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
  end
  // One command per edge, held until the next one
  task automatic issue(input logic c, input logic [9:0] r,
                       input logic [9:0] f);
    @(posedge clk);
    cke <= c;
    cs_n <= 1'b0;
    ca_rise <= r;
    ca_fall <= f;
  endtask
  // Deselect; stale bits flipped so nothing leans on them
  task automatic no_op_cmd(input int n);
    repeat (n) begin
      @(posedge clk);
      cs_n <= 1'b0 ^ 1'b1;
      ca_rise <= ~ca_rise;
      ca_fall <= ~ca_fall;
    end
  endtask
  task automatic mode_reg_write_cmd(input logic [7:0] a, input logic [7:0] d);
    issue(1'b1, {a[7:2], 4'h0}, {d, a[1:0]});
    no_op_cmd(6);
  endtask
  // No read or write burst is ever issued, so none needs spacing here
  task automatic mode_reg_read_cmd(input logic [7:0] a);
    issue(1'b1, {a[7:2], 4'h8}, {8'h00, a[1:0]});
    no_op_cmd(1);
  endtask
  // Banks are idle here; clock enable was high the cycle before
  task automatic sr_enter();
    issue(1'b0, 10'h004, 10'h000);
    no_op_cmd(1);
  endtask
  // Long stay before exit; clock never stopped here
  task automatic sr_exit();
    no_op_cmd(4);
    @(posedge clk);
    cke <= 1'b1;
  endtask
  task automatic refresh();
    issue(1'b1, 10'h00C, 10'h000);
    no_op_cmd(2);
  endtask
endmodule
`default_nettype wire

// file: tb/lsr_device_props.sv
// Checker for self refresh and register read behaviour
`timescale 1ns/1ps
`default_nettype none
module lsr_device_props
  import lsr_pkg::*;
#(
  parameter int READ_LAT = 3
) (
  input wire logic       clk,          // Memory clock
  input wire logic       srst,         // Sync reset
  input wire logic       cke,          // Clock enable
  input wire logic       cs_n,         // Chip select
  input wire logic [9:0] ca_rise,      // Rising bits
  input wire logic       dq_oe,        // Data enable
  input wire logic [3:0] dqs_out,      // Strobes
  input wire logic       dqs_oe,       // Strobe enable
  input wire logic       in_selfref,   // Self refresh
  input wire logic       in_exit,      // Exit interval
  input wire lsr_mask_t  bank_refresh  // Refresh step
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Entry needs a falling clock enable
  sequence entry_s;
    !cke && $past(cke) && !cs_n && ca_rise[2:0] == 3'b100
      && !in_selfref && !in_exit;
  endsequence
  sequence mrr_s;
    cke && !cs_n && ca_rise[3:0] == 4'h8 && !in_selfref
      && !in_exit && !dq_oe;
  endsequence
  sequence burst_s;
    dq_oe [*4] ##1 !dq_oe;
  endsequence
  sr_entry_a: assert property (entry_s |=> in_selfref)
    else $error("self refresh not entered");
  sr_hold_a: assert property (in_selfref && !cke |=> in_selfref)
    else $error("self refresh left early");
  sr_exit_a: assert property (in_selfref && cke |=> in_exit)
    else $error("exit not started");
  exit_len_a: assert property ($rose(in_exit) |-> in_exit [*3])
    else $error("exit interval short");
  refresh_gate_a: assert property (bank_refresh != 8'h00 |->
    in_selfref || in_exit || $past(in_exit))
    else $error("refresh outside self refresh");
  strobe_en_a: assert property (dqs_oe == dq_oe)
    else $error("strobe enable differs");
  read_burst_a: assert property ($rose(dq_oe) |-> burst_s)
    else $error("burst not four beats");
  strobe_tog_a: assert property (dq_oe && $past(dq_oe) |->
    dqs_out != $past(dqs_out))
    else $error("strobe not toggling");
  regread_a: assert property (mrr_s |-> ##[1:12] $rose(dq_oe))
    else $error("register read gave no data");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Top testbench for the self refresh device block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lsr_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cke, cs_n, dq_oe, dqs_oe, in_selfref, in_exit, cmd_ignored;
  logic [9:0]  ca_rise, ca_fall;
  logic [31:0] dq_out;
  logic [3:0]  dqs_out;
  logic [2:0]  seg_refresh;
  lsr_mask_t   bank_refresh;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  // Free-running memory clock
  always #25 clk = ~clk;
  lsr_ctrl_model u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall));
  lsr_device #(.READ_LAT(3)) DUT (.clk(clk), .srst(srst), .cke(cke),
    .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .in_selfref(in_selfref), .in_exit(in_exit),
    .cmd_ignored(cmd_ignored), .bank_refresh(bank_refresh),
    .seg_refresh(seg_refresh));
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Write-only masks read back zero on the first beat
  task automatic t_regread();
    int n;
    u_ctl.mode_reg_read_cmd(8'h10);
    n = 0;
    #1;
    while (dq_oe !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("beat_oe", dq_oe, 1'b1);
    check("beat0", dq_out[7:0], 8'h00);
    n = 0;
    repeat (6) begin
      n += (dq_oe === 1'b1);
      @(posedge clk);
      #1;
    end
    check("beats", n, 4);
  endtask
  // All-masked write inside the read period must be refused
  task automatic t_ignore();
    logic hit;
    hit = 1'b0;
    // Register read, then a write on the very next edge inside the period
    u_ctl.issue(1'b1, 10'h048, 10'h000);
    u_ctl.issue(1'b1, 10'h040, 10'h3FC);
    repeat (3) begin
      u_ctl.no_op_cmd(1);
      #1;
      hit |= (cmd_ignored === 1'b1);
    end
    check("ignored", hit, 1'b1);
    u_ctl.no_op_cmd(10);
  endtask
  // Banks 1,7 and segments 2,7 masked; only unmasked pairs refreshed
  task automatic t_selfref();
    logic [7:0] seen;
    int n;
    seen = 8'h00;
    u_ctl.mode_reg_write_cmd(8'h10, 8'h82);
    u_ctl.mode_reg_write_cmd(8'h11, 8'h84);
    u_ctl.sr_enter();
    repeat (200) begin
      @(posedge clk);
      #1;
      if (bank_refresh !== 8'h00) begin
        check("banks", bank_refresh, 8'h7D);
        seen[seg_refresh] = 1'b1;
      end
    end
    check("selfref", in_selfref, 1'b1);
    check("segs", seen, 8'h7B);
    u_ctl.sr_exit();
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      n += (in_exit === 1'b1);
    end
    check("exit", n >= 3 && in_selfref === 1'b0, 1'b1);
    u_ctl.refresh();
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regread();
    t_ignore();
    t_selfref();
    stop_test();
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      stop_test();
    end
  end
endmodule
bind lsr_device lsr_device_props #(.READ_LAT(READ_LAT)) u_props (
  .clk(clk), .srst(srst), .cke(cke), .cs_n(cs_n), .ca_rise(ca_rise),
  .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
  .in_selfref(in_selfref), .in_exit(in_exit),
  .bank_refresh(bank_refresh));
`default_nettype wire
